// ---- sci_sync.v ----
`include "sci_regs.vh"
module sci_sync #(
    parameter DIV_W = 16
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire serial_receive_input,
    output reg txd_out,
    output wire txd_oe_n,
    output reg sclk_out,
    output wire sclk_oe_n,
    output wire irq
);
    localparam RX_IDLE = 3'b001;
    localparam RX_VERIFY = 3'b010;
    localparam RX_DATA = 3'b100;
    localparam TX_IDLE = 3'b001;
    localparam TX_PRE = 3'b010;
    localparam TX_FRAME = 3'b100;
    localparam [3:0] STOP_IDX = 4'h9;
    localparam [3:0] LAST_DATA = 4'h8;

    // bus-visible registers
    reg [5:0] serial_control_one_r;
    reg [DIV_W-1:0] baud_r;
    reg [3:0] stat_r;
    reg [3:0] mask_r;
    reg [7:0] rx_data_r;
    reg [7:0] tx_data_r;
    reg tx_pend_r;

    // receiver line sync and sampling
    reg rx_meta_r;
    reg rx_sync_r;
    reg [DIV_W-1:0] div_cnt_r;
    reg [2:0] rx_state_r;
    reg [3:0] rx_rt_r;
    reg [3:0] rx_bit_r;
    reg [2:0] rx_samp_r;
    reg [8:0] rx_shift_r;
    reg rx_noise_r;

    // transmitter frame and clock
    reg [2:0] tx_state_r;
    reg [3:0] tx_rt_r;
    reg [3:0] tx_bit_r;
    reg [9:0] tx_shift_r;
    reg te_d_r;
    reg [3:0] ev;

    wire last_bit_clock_enable = serial_control_one_r[`CTL_LAST_BIT_CLOCK_ENABLE];
    wire clock_phase_select = serial_control_one_r[`CTL_CLOCK_PHASE_SELECT];
    wire clock_polarity_select = serial_control_one_r[`CTL_CLOCK_POLARITY_SELECT];
    wire transmitter_enable = serial_control_one_r[`CTL_TE];
    wire receiver_enable = serial_control_one_r[`CTL_RE];
    wire send_break = serial_control_one_r[`CTL_SBK];

    wire wr = psel & penable & pwrite;
    wire rd_ok = (paddr == `ADDR_CTRL) || (paddr == `ADDR_BAUD) ||
                 (paddr == `ADDR_TXD) || (paddr == `ADDR_RXD) ||
                 (paddr == `ADDR_STAT) || (paddr == `ADDR_MASK) ||
                 (paddr == `ADDR_STATE);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~rd_ok;
    assign irq = |(stat_r & mask_r);

    // one receiver tick per baud divider wrap
    wire receiver_tick = ce && (div_cnt_r == baud_r);

    // majority and agreement of three samples
    function vote;
        input [2:0] s;
        begin
            vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
        end
    endfunction

    wire [2:0] samp_now = {rx_samp_r[1:0], rx_sync_r};
    wire bit_val = vote(samp_now);
    wire bit_noisy = (samp_now != 3'b000) && (samp_now != 3'b111);
    // at least two low of three verify samples
    wire start_ok = ~vote(samp_now);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
        end else if (ce) begin
            rx_meta_r <= serial_receive_input;
            rx_sync_r <= rx_meta_r;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= {DIV_W{1'b0}};
        end else if (ce) begin
            if (div_cnt_r >= baud_r) begin
                div_cnt_r <= {DIV_W{1'b0}};
            end else begin
                div_cnt_r <= div_cnt_r + 1'b1;
            end
        end
    end

    // receiver: uses no clock output options
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_r <= RX_IDLE;
            rx_rt_r <= 4'h0;
            rx_bit_r <= 4'h0;
            rx_samp_r <= 3'b000;
            rx_shift_r <= 9'h000;
            rx_noise_r <= 1'b0;
            rx_data_r <= 8'h00;
        end else if (ce) begin
            if (!receiver_enable) begin
                rx_state_r <= RX_IDLE;
            end else if (receiver_tick) begin
                case (rx_state_r)
                    RX_IDLE: begin
                        if (!rx_sync_r) begin
                            // this tick counts as tick 1 of the start bit
                            rx_state_r <= RX_VERIFY;
                            rx_rt_r <= 4'h2;
                            rx_bit_r <= 4'h0;
                            rx_noise_r <= 1'b0;
                        end
                    end
                    RX_VERIFY: begin
                        rx_rt_r <= rx_rt_r + 4'h1;
                        if (rx_rt_r == `RT_VERIFY_A || rx_rt_r == `RT_VERIFY_B) begin
                            rx_samp_r <= samp_now;
                        end
                        if (rx_rt_r == `RT_VERIFY_C) begin
                            if (start_ok) begin
                                rx_state_r <= RX_DATA;
                                rx_noise_r <= |samp_now;
                            end else begin
                                rx_state_r <= RX_IDLE;
                            end
                        end
                    end
                    RX_DATA: begin
                        rx_rt_r <= rx_rt_r + 4'h1;
                        if (rx_rt_r == `RT_SAMPLE_A || rx_rt_r == `RT_SAMPLE_B) begin
                            rx_samp_r <= samp_now;
                        end
                        if (rx_rt_r == `RT_SAMPLE_C) begin
                            rx_shift_r <= {bit_val, rx_shift_r[8:1]};
                            if (bit_noisy) begin
                                rx_noise_r <= 1'b1;
                            end
                            if (rx_bit_r == STOP_IDX) begin
                                rx_data_r <= rx_shift_r[8:1];
                                rx_state_r <= RX_IDLE;
                            end
                        end
                        if (rx_rt_r == `TICKS_PER_BIT) begin
                            rx_rt_r <= 4'h0;
                            rx_bit_r <= rx_bit_r + 4'h1;
                        end
                    end
                    default: rx_state_r <= RX_IDLE;
                endcase
            end
        end
    end

    wire rx_done = receiver_enable && receiver_tick && rx_state_r == RX_DATA &&
                   rx_rt_r == `RT_SAMPLE_C && rx_bit_r == STOP_IDX;

    wire tx_bit_end = receiver_tick && tx_rt_r == `TICKS_PER_BIT;
    wire tx_start = tx_state_r == TX_IDLE && tx_pend_r && !send_break;

    // transmitter state, preamble on enable
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_r <= TX_IDLE;
            tx_rt_r <= 4'h0;
            tx_bit_r <= 4'h0;
            tx_shift_r <= 10'h3ff;
            te_d_r <= 1'b0;
        end else if (ce) begin
            te_d_r <= transmitter_enable;
            if (!transmitter_enable) begin
                tx_state_r <= TX_IDLE;
            end else if (!te_d_r) begin
                tx_state_r <= TX_PRE;
                tx_rt_r <= 4'h0;
                tx_bit_r <= 4'h0;
                tx_shift_r <= 10'h3ff;
            end else begin
                case (tx_state_r)
                    TX_IDLE: begin
                        if (tx_start) begin
                            tx_state_r <= TX_FRAME;
                            tx_rt_r <= 4'h0;
                            tx_bit_r <= 4'h0;
                            tx_shift_r <= {1'b1, tx_data_r, 1'b0};
                        end
                    end
                    TX_PRE, TX_FRAME: begin
                        if (receiver_tick) begin
                            tx_rt_r <= tx_rt_r + 4'h1;
                        end
                        if (tx_bit_end) begin
                            tx_rt_r <= 4'h0;
                            tx_bit_r <= tx_bit_r + 4'h1;
                            tx_shift_r <= {1'b1, tx_shift_r[9:1]};
                            if (tx_bit_r == STOP_IDX) begin
                                tx_state_r <= TX_IDLE;
                            end
                        end
                    end
                    default: tx_state_r <= TX_IDLE;
                endcase
            end
        end
    end

    wire tx_done = tx_state_r == TX_FRAME && tx_bit_end && tx_bit_r == STOP_IDX;

    // clock only in data bits 1..8; last one optional
    wire data_bit = tx_state_r == TX_FRAME && tx_bit_r != 4'h0 &&
                    tx_bit_r != STOP_IDX;
    wire clk_on = data_bit && (tx_bit_r != LAST_DATA || last_bit_clock_enable);
    wire first_half = tx_rt_r < `RT_HALF;
    // phase picks which half of the bit holds the pulse
    wire pulse = clk_on && (clock_phase_select ? first_half : !first_half);

    // break holds the line low only between frames
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_out <= 1'b1;
        end else if (ce) begin
            txd_out <= (tx_state_r == TX_IDLE && send_break) ? 1'b0 : tx_shift_r[0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_out <= 1'b0;
        end else if (ce) begin
            sclk_out <= clock_polarity_select ^ pulse;
        end
    end

    assign txd_oe_n = ~transmitter_enable;
    assign sclk_oe_n = ~transmitter_enable;

    always @* begin
        ev = 4'h0;
        ev[`EV_RX] = rx_done;
        ev[`EV_NOISE] = rx_done && (rx_noise_r || bit_noisy);
        ev[`EV_FRAME] = rx_done && !bit_val;
        ev[`EV_TX] = tx_done;
    end

    // register decode, one select per word
    wire sel_ctrl = (paddr == `ADDR_CTRL);
    wire sel_baud = (paddr == `ADDR_BAUD);
    wire sel_txd = (paddr == `ADDR_TXD);
    wire sel_rxd = (paddr == `ADDR_RXD);
    wire sel_stat = (paddr == `ADDR_STAT);
    wire sel_mask = (paddr == `ADDR_MASK);
    wire sel_state = (paddr == `ADDR_STATE);

    wire rx_busy = rx_state_r != RX_IDLE;
    wire tx_busy = tx_state_r != TX_IDLE;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_control_one_r <= `CTL_RESET;
        end else if (ce && wr && sel_ctrl) begin
            serial_control_one_r <= pwdata[5:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_r <= `BAUD_RESET;
        end else if (ce && wr && sel_baud) begin
            baud_r <= pwdata[DIV_W-1:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= 4'h0;
        end else if (ce && wr && sel_mask) begin
            mask_r <= pwdata[3:0];
        end
    end

    // last written byte, read back as written
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_data_r <= 8'h00;
        end else if (ce && wr && sel_txd) begin
            tx_data_r <= pwdata[7:0];
        end
    end

    // one pending byte; a write while disabled is dropped
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pend_r <= 1'b0;
        end else if (ce) begin
            if (wr && sel_txd) begin
                tx_pend_r <= transmitter_enable;
            end else if (tx_start) begin
                tx_pend_r <= 1'b0;
            end
        end
    end

    // sticky status, one bit per event
    wire [3:0] stat_nxt;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_stat
            // a set beats a write-one clear in the same cycle
            assign stat_nxt[gi] = ev[gi] | (stat_r[gi] & ~(wr & sel_stat & pwdata[gi]));
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= 4'h0;
        end else if (ce) begin
            stat_r <= stat_nxt;
        end
    end

    // read word for the addressed register
    reg [31:0] rdata_nxt;
    always @* begin
        rdata_nxt = 32'h0000_0000;
        if (sel_ctrl) begin
            rdata_nxt[5:0] = serial_control_one_r;
        end
        if (sel_baud) begin
            rdata_nxt[DIV_W-1:0] = baud_r;
        end
        if (sel_txd) begin
            rdata_nxt[7:0] = tx_data_r;
        end
        if (sel_rxd) begin
            rdata_nxt[7:0] = rx_data_r;
        end
        if (sel_stat) begin
            rdata_nxt[3:0] = stat_r;
        end
        if (sel_mask) begin
            rdata_nxt[3:0] = mask_r;
        end
        if (sel_state) begin
            rdata_nxt[2:0] = {tx_pend_r, tx_busy, rx_busy};
        end
    end

    // read data launched at the setup edge, held through access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable) begin
            prdata <= rdata_nxt;
        end
    end
endmodule // sci_sync

// ---- sci_regs.vh ----
`ifndef SCI_REGS_VH
`define SCI_REGS_VH
// How it works
// - receiver samples at sixteen ticks per bit
// - each start bit restarts receiver bit timing
// - bits sampled at ticks 8, 9, 10
// - bit value is majority of three samples
// - unequal samples on any bit set noise
// - start accepted if two of three verify low
// - any high verify sample sets noise
// - transmitter drives dedicated synchronous clock output
// - no clock during start or stop bit
// - control bit 0 gates last bit clock
// - control bit 2 sets clock polarity
// - control bit 1 sets clock phase
// - clock idle during idle, preamble, break
// - clock options never affect the receiver
// - transmitter disabled floats clock and data pins

`define ADDR_CTRL 12'h000
`define ADDR_BAUD 12'h004
`define ADDR_TXD 12'h008
`define ADDR_RXD 12'h00c
`define ADDR_STAT 12'h010
`define ADDR_MASK 12'h014
`define ADDR_STATE 12'h018

`define CTL_LAST_BIT_CLOCK_ENABLE 0
`define CTL_CLOCK_PHASE_SELECT 1
`define CTL_CLOCK_POLARITY_SELECT 2
`define CTL_TE 3
`define CTL_RE 4
`define CTL_SBK 5
`define CTL_RESET 6'h00
`define BAUD_RESET 16'h0000

`define EV_RX 0
`define EV_NOISE 1
`define EV_FRAME 2
`define EV_TX 3

`define TICKS_PER_BIT 4'hf
`define RT_SAMPLE_A 4'h8
`define RT_SAMPLE_B 4'h9
`define RT_SAMPLE_C 4'ha
`define RT_VERIFY_A 4'h3
`define RT_VERIFY_B 4'h5
`define RT_VERIFY_C 4'h7
`define RT_HALF 4'h8
`define PREAMBLE_BITS 4'ha
`endif

// ---- sci_sync_props.sv ----
`include "sci_regs.vh"
module sci_sync_props (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire txd_oe_n,
    input wire sclk_out,
    input wire sclk_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc; psel && penable; endsequence
    sequence s_wr_ctrl; psel && penable && pwrite && ce && paddr == `ADDR_CTRL; endsequence
    sequence s_te_on; $fell(txd_oe_n); endsequence
    a_ready_high: assert property (s_acc |-> pready) else $error("ready low");
    a_err_access: assert property (pslverr |-> psel && penable) else $error("stray error");
    a_unmapped_err: assert property (s_acc ##0 paddr > `ADDR_STATE |-> pslverr)
        else $error("unmapped not refused");
    a_mapped_ok: assert property (s_acc ##0 (paddr <= `ADDR_STATE && paddr[1:0] == 2'b00)
        |-> !pslverr) else $error("mapped refused");
    a_err_read_zero: assert property (s_acc ##0 (!pwrite && pslverr) |-> prdata == 32'h0)
        else $error("unmapped read data");
    a_oe_pair: assert property (txd_oe_n == sclk_oe_n)
        else $error("enables differ");
    a_oe_from_ctrl: assert property (s_wr_ctrl |=> ##1 txd_oe_n == !$past(pwdata[3], 2))
        else $error("enable not from control");
    a_idle_level: assert property (s_wr_ctrl |=> ##1 sclk_out == $past(pwdata[2], 2))
        else $error("clock idle level");
    a_preamble_quiet: assert property (s_te_on |-> ##2 $stable(sclk_out)[*8])
        else $error("clock during preamble");
endmodule // sci_sync_props
bind sci_sync sci_sync_props u_props (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txd_oe_n(txd_oe_n), .sclk_out(sclk_out),
    .sclk_oe_n(sclk_oe_n));

// ---- serial_far_end.sv ----
module serial_far_end #(
    parameter int BIT_CYC = 32
) (
    input wire logic pclk,
    output logic rx_line,
    input wire logic txd_out,
    input wire logic sclk_out,
    input wire logic pol,
    input wire logic pha,
    output logic [7:0] shift_r,
    output int pulses
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sclk_d = 1'b0;
    initial rx_line = 1'b1;
    // capture mid-bit: leading edge in phase 0, trailing edge in phase 1
    always @(posedge pclk) begin
        sclk_d <= sclk_out;
        if (sclk_out !== sclk_d && sclk_out === !(pol ^ pha)) begin
            shift_r <= {txd_out, shift_r[7:1]};
            pulses <= pulses + 1;
        end
    end
    task clear;
        shift_r <= 8'h00;
        pulses <= 0;
    endtask
    // g > 0 flips the line for two cycles from offset g
    task send(input logic [7:0] d, input logic stop, input int g);
        logic [9:0] fr;
        fr = {stop, d, 1'b0};
        for (int n = 0; n < 10 * BIT_CYC; n++) begin
            @(posedge pclk);
            rx_line <= fr[n / BIT_CYC] ^ (g > 0 && n >= g && n < g + 2);
        end
        @(posedge pclk);
        rx_line <= 1'b1;
    endtask
    task pulse_low(input int len);
        @(posedge pclk);
        rx_line <= 1'b0;
        repeat (len) @(posedge pclk);
        rx_line <= 1'b1;
    endtask
endmodule // serial_far_end

// ---- sci_sync_tb.sv ----
`include "sci_regs.vh"
module sci_sync_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, ce, psel, penable, pwrite, pol_r, pha_r, last_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, q;
    wire [31:0] prdata;
    wire pready, pslverr, rx_line, txd_out, txd_oe_n, sclk_out, sclk_oe_n, irq;
    wire [7:0] far_shift;
    int far_pulses, failures = 0, samples_checked = 0, cycles = 0, i;
    task report_and_stop;
        if (failures == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d); apb(a, 1'b1, d); endtask
    task rd(input logic [11:0] a); apb(a, 1'b0, 32'h0); endtask
    task rx_case(input string nm, input logic [7:0] d, input logic s, input int g,
        input logic [31:0] st);
        u_far.send(d, s, g);
        rd(`ADDR_RXD);
        chk({nm, " data"}, {24'h0, d}, q);
        rd(`ADDR_STAT);
        chk({nm, " status"}, st, q);
        wr(`ADDR_STAT, 32'hf);
    endtask
    sci_sync i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_receive_input(rx_line), .txd_out(txd_out),
        .txd_oe_n(txd_oe_n), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .irq(irq));
    serial_far_end u_far (.pclk(pclk), .rx_line(rx_line), .txd_out(txd_out),
        .sclk_out(sclk_out), .pol(pol_r), .pha(pha_r), .shift_r(far_shift), .pulses(far_pulses));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            report_and_stop;
        end
    end
    initial begin
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pol_r = 1'b0;
        pha_r = 1'b0;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(`ADDR_CTRL);
        chk("ctrl reset", 32'h0, q);
        rd(`ADDR_STATE);
        chk("state reset", 32'h0, q);
        rd(12'h01c);
        chk("unmapped", 32'h1, {31'h0, last_err});
        wr(`ADDR_BAUD, 32'h1);
        rd(`ADDR_BAUD);
        chk("baud", 32'h1, q);
        ce <= 1'b0;
        wr(`ADDR_MASK, 32'hf);
        ce <= 1'b1;
        rd(`ADDR_MASK);
        chk("frozen write", 32'h0, q);
        wr(`ADDR_CTRL, 32'h17);
        u_far.send(8'h5a, 1'b1, 0);
        rx_case("back", 8'hc3, 1'b1, 0, 32'h1);
        u_far.send(8'h81, 1'b1, 0);
        @(posedge pclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`ADDR_MASK, 32'h1);
        @(posedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`ADDR_STAT, 32'h1);
        @(posedge pclk);
        chk("irq clr", 32'h0, {31'h0, irq});
        wr(`ADDR_MASK, 32'h0);
        u_far.pulse_low(4);
        repeat (400) @(posedge pclk);
        rd(`ADDR_STAT);
        chk("short start", 32'h0, q);
        rx_case("verify", 8'h3c, 1'b1, 8, 32'h3);
        rx_case("start", 8'h0f, 1'b1, 16, 32'h3);
        rx_case("data", 8'ha5, 1'b1, 112, 32'h3);
        rx_case("stop", 8'h66, 1'b0, 0, 32'h5);
        for (i = 0; i < 8; i++) begin
            pol_r <= i[2];
            pha_r <= i[1];
            wr(`ADDR_CTRL, i);
            wr(`ADDR_CTRL, i | 8);
            u_far.clear();
            wr(`ADDR_TXD, 32'h96);
            do rd(`ADDR_STAT); while (q[3] !== 1'b1);
            chk("pulses", 7 + i[0], far_pulses);
            chk("shift", i[0] ? 32'h96 : 32'h2c, {24'h0, far_shift});
            chk("idle clock", {31'h0, i[2]}, {31'h0, sclk_out});
            wr(`ADDR_CTRL, i);
            @(posedge pclk);
            chk("float", 32'h3, {30'h0, txd_oe_n, sclk_oe_n});
            wr(`ADDR_STAT, 32'hf);
        end
        pol_r <= 1'b0;
        pha_r <= 1'b0;
        wr(`ADDR_CTRL, 32'h28);
        u_far.clear();
        repeat (800) @(posedge pclk);
        chk("break line", 32'h0, {31'h0, txd_out});
        chk("break clock", 32'h0, far_pulses);
        wr(`ADDR_CTRL, 32'h0);
        report_and_stop;
    end
endmodule // sci_sync_tb
